/* File: rtl/usc_map.vh */
// Behaviour
// - data words of seven, eight or nine bits; nine bits for multi-controller addressing.
// - each character ends with one or two stop bits as configured.
// - one start bit always; parity optional, even or odd.
// - configuration selects msb-first or lsb-first shifting.
// - multi-controller mode neither generates nor checks parity.
// - clock from external pin or system clock, prescaler dividing by 2 to 256, then baud divisor.
// - clock-select bits 6 and 5 pick clock source and generator bypass.
// - bypassed generator outputs input clock or input divided by 16.
// - oversample clock drives serial clock pin; divide select changes only that pin.
// - prescaled clock divided by divisor plus one; bit rate is that over 16.
// - baud divisor is 8 bits, ratios 1 through 256.
// - writing transmit fifo starts transmission; parity appended when enabled.
// - transmit shift register 12 bits loaded from fifo; bit 0 goes out first.
// - both ends use identical rate, length, parity and stop settings.
// - low input is a start bit only when previous sample was high.
// - 16x oversampling; sample ticks 7, 8, 9 by majority vote.
// - receive shift register 10 bits; bit 0 holds first data bit received.
// - each complete word goes parallel then into the receive fifo, or is dropped when the fifo is full.
// - fifo service by polling, interrupt or dma via status levels.
// - transmit and receive fifos each hold two entries.
// - line mode 0x2 or 0x3 is multi-controller; wake-up bit marks address frames.
`ifndef USC_MAP_VH
`define USC_MAP_VH
`define USC_CS_SRC_BIT   6
`define USC_CS_BYP_BIT   5
`define USC_OVS          5'h10
`define USC_SMP_A        4'h6
`define USC_SMP_B        4'h7
`define USC_SMP_C        4'h8
`define USC_FIFO_DEPTH   2'h2
`define USC_MODE_MC_BIT  1
`define USC_LEN_7        2'h0
`define USC_LEN_8        2'h1
`define USC_LEN_9        2'h2
`endif

/* File: rtl/usc_core.v */
`timescale 1ns/1ns
`default_nettype none
`include "usc_map.vh"
module usc_core (
    input  wire        ref_clk_i,
    input  wire        resetn_i,
    input  wire        ext_clk_i,
    input  wire [1:0]  clock_select_i,
    input  wire        clock_out_divide_select_i,
    input  wire [2:0]  prescale_sel_i,
    input  wire [7:0]  baud_divisor_i,
    input  wire [1:0]  data_len_i,
    input  wire        two_stop_i,
    input  wire        parity_en_i,
    input  wire        parity_odd_i,
    input  wire        msb_first_i,
    input  wire [1:0]  line_mode_field_i,
    input  wire        tx_wake_up_bit_i,
    input  wire        rx_enable_i,
    input  wire [7:0]  tx_data_i,
    input  wire        tx_valid_i,
    output wire        tx_ready_o,
    output wire [7:0]  rx_data_o,
    output wire        rx_extra_o,
    output wire        rx_valid_o,
    input  wire        rx_ready_i,
    input  wire        rxd_i,
    output reg         txd_o,
    output reg         serial_clk_o,
    output wire        tx_fifo_empty_o,
    output wire        rx_fifo_full_o
);
    // clock source: ext pin sampled as synchronous input, rising edge gives a tick
    reg        ext_q;
    wire       src_int  = ~clock_select_i[1];
    wire       ext_tick = ext_clk_i & ~ext_q;
    wire       in_tick  = src_int ? 1'b1 : ext_tick;
    wire       bypass   = clock_select_i[0];
    reg  [7:0] pre_cnt_q;
    reg  [7:0] brd_cnt_q;
    reg  [3:0] div16_q;
    wire [7:0] pre_lim  = (8'h02 << prescale_sel_i) - 8'h01;
    // compare at or above limit so a lowered setting cannot strand a counter
    wire       pre_tick = in_tick & (pre_cnt_q >= pre_lim);
    // oversample tick: divisor+1 division of prescaled clock, or bypass
    wire       brd_tick = pre_tick & (brd_cnt_q >= baud_divisor_i);
    wire       ovs_tick = bypass ? in_tick : brd_tick;
    wire       pin_tick = (bypass & clock_out_divide_select_i) ?
                          (ovs_tick & (div16_q == 4'hF)) : ovs_tick;
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_q        <= 1'b0;
            pre_cnt_q    <= 8'h00;
            brd_cnt_q    <= 8'h00;
            div16_q      <= 4'h0;
            serial_clk_o <= 1'b0;
        end else begin
            ext_q <= ext_clk_i;
            if (in_tick)
                pre_cnt_q <= pre_tick ? 8'h00 : pre_cnt_q + 8'h01;
            if (pre_tick)
                brd_cnt_q <= brd_tick ? 8'h00 : brd_cnt_q + 8'h01;
            if (ovs_tick)
                div16_q <= div16_q + 4'h1;
            // pin toggles only; baud path untouched
            if (pin_tick)
                serial_clk_o <= ~serial_clk_o;
        end
    end
    // selection happens in src_int and bypass above

    wire mc_mode = line_mode_field_i[`USC_MODE_MC_BIT];
    wire par_on  = parity_en_i & ~mc_mode;
    // last data bit is wake-up bit in multi-controller mode
    wire [3:0] nbits = (data_len_i == `USC_LEN_7) ? 4'h7 :
                       (data_len_i == `USC_LEN_8) ? 4'h8 : 4'h9;

    reg  [8:0] txf_q [0:1];
    reg  [8:0] rxf_q [0:1];
    reg        txw_q, txr_q, rxw_q, rxr_q;
    reg  [1:0] txn_q, rxn_q;
    wire       tx_push = tx_valid_i & tx_ready_o;
    wire       rx_pop  = rx_valid_o & rx_ready_i;
    // status levels serve polling, interrupt or dma logic outside
    assign tx_ready_o      = (txn_q != `USC_FIFO_DEPTH);
    assign tx_fifo_empty_o = (txn_q == 2'h0);
    assign rx_valid_o      = (rxn_q != 2'h0);
    assign rx_fifo_full_o  = (rxn_q == `USC_FIFO_DEPTH);
    assign rx_data_o       = rxf_q[rxr_q][7:0];
    assign rx_extra_o      = rxf_q[rxr_q][8];

    // transmitter
    localparam TX_IDLE = 2'h0;
    localparam TX_RUN  = 2'h1;
    reg  [1:0] tx_st_q;
    reg  [3:0] tx_ovs_q;
    reg  [3:0] tx_bit_q;
    reg  [3:0] tx_tot_q;
    reg  [11:0] tx_sh_q;
    wire       tx_pop  = (tx_st_q == TX_IDLE) & (txn_q != 2'h0) & ovs_tick;
    wire [8:0] tw      = txf_q[txr_q];
    reg  [8:0] tx_word;
    reg  [3:0] tx_len;
    integer    i;
    always @* begin
        tx_word = 9'h000;
        for (i = 0; i < 9; i = i + 1) begin
            if (i < nbits)
                tx_word[i] = msb_first_i ? tw[nbits - 1 - i] : tw[i];
        end
        // wake-up bit stored with the word, not the live pin
        if (mc_mode)
            tx_word[nbits - 4'h1] = tw[8];
        tx_len = 4'h1 + nbits + {3'h0, par_on} + 4'h1 + {3'h0, two_stop_i};
    end
    wire tx_par = (^(tx_word & ~(9'h1FF << nbits))) ^ parity_odd_i;
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_st_q  <= TX_IDLE;
            tx_ovs_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_tot_q <= 4'h0;
            tx_sh_q  <= 12'hFFF;
            txd_o    <= 1'b1;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    txd_o <= 1'b1;
                    if (tx_pop) begin
                        if (par_on)
                            tx_sh_q <= (12'hFFF << (nbits + 4'h1)) |
                                       ({11'h000, tx_par} << nbits) | {3'h0, tx_word};
                        else
                            tx_sh_q <= (12'hFFF << nbits) | {3'h0, tx_word};
                        txd_o    <= 1'b0;
                        tx_ovs_q <= 4'h0;
                        tx_bit_q <= 4'h0;
                        tx_tot_q <= tx_len;
                        tx_st_q  <= TX_RUN;
                    end
                end
                TX_RUN: begin
                    if (ovs_tick) begin
                        tx_ovs_q <= tx_ovs_q + 4'h1;
                        if (tx_ovs_q == 4'hF) begin
                            tx_bit_q <= tx_bit_q + 4'h1;
                            if (tx_bit_q + 4'h1 == tx_tot_q) begin
                                txd_o   <= 1'b1;
                                tx_st_q <= TX_IDLE;
                            end else begin
                                // stop bits shift in as ones
                                txd_o   <= tx_sh_q[0];
                                tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                            end
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // receiver
    localparam RX_IDLE = 2'h0;
    localparam RX_RUN  = 2'h1;
    reg  [1:0] rx_st_q;
    reg  [3:0] rx_ovs_q;
    reg  [3:0] rx_bit_q;
    reg  [2:0] rx_vote_q;
    reg        rx_prev_q;
    reg  [9:0] rx_sh_q;
    wire       maj = (rx_vote_q[0] & rx_vote_q[1]) | (rx_vote_q[0] & rx_vote_q[2]) |
                     (rx_vote_q[1] & rx_vote_q[2]);
    wire [3:0] rx_last = nbits + {3'h0, par_on};
    wire       rx_done = (rx_st_q == RX_RUN) & ovs_tick & (rx_ovs_q == 4'hF) &
                         (rx_bit_q == rx_last + 4'h1);
    reg  [8:0] rx_word;
    integer    k;
    always @* begin
        rx_word = 9'h000;
        // bit 0 holds first received bit in lsb mode
        for (k = 0; k < 9; k = k + 1) begin
            if (k < nbits)
                rx_word[k] = msb_first_i ? rx_sh_q[nbits - 1 - k] : rx_sh_q[k];
        end
        if (mc_mode)
            rx_word[8] = rx_sh_q[nbits - 4'h1];
    end
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st_q   <= RX_IDLE;
            rx_ovs_q  <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_vote_q <= 3'h7;
            rx_prev_q <= 1'b1;
            rx_sh_q   <= 10'h000;
        end else if (ovs_tick) begin
            case (rx_st_q)
                RX_IDLE: begin
                    rx_prev_q <= rxd_i;
                    if (rx_enable_i & rx_prev_q & ~rxd_i) begin
                        rx_st_q  <= RX_RUN;
                        rx_ovs_q <= 4'h1;
                        rx_bit_q <= 4'h0;
                    end
                end
                RX_RUN: begin
                    rx_ovs_q <= rx_ovs_q + 4'h1;
                    if (rx_ovs_q == `USC_SMP_A)
                        rx_vote_q[0] <= rxd_i;
                    if (rx_ovs_q == `USC_SMP_B)
                        rx_vote_q[1] <= rxd_i;
                    if (rx_ovs_q == `USC_SMP_C)
                        rx_vote_q[2] <= rxd_i;
                    if (rx_ovs_q == 4'hF) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'h0 && maj) begin
                            rx_st_q   <= RX_IDLE;
                            rx_prev_q <= 1'b1;
                        end else if (rx_bit_q != 4'h0 && rx_bit_q <= nbits) begin
                            rx_sh_q[rx_bit_q - 4'h1] <= maj;
                        end
                        if (rx_done) begin
                            rx_st_q   <= RX_IDLE;
                            rx_prev_q <= maj;
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // fifo pointers; rx word dropped when full
    wire rx_push = rx_done & (rxn_q != `USC_FIFO_DEPTH);
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            txw_q <= 1'b0;
            txr_q <= 1'b0;
            txn_q <= 2'h0;
            rxw_q <= 1'b0;
            rxr_q <= 1'b0;
            rxn_q <= 2'h0;
        end else begin
            if (tx_push)
                txw_q <= ~txw_q;
            if (tx_pop)
                txr_q <= ~txr_q;
            txn_q <= txn_q + {1'b0, tx_push} - {1'b0, tx_pop};
            if (rx_push)
                rxw_q <= ~rxw_q;
            if (rx_pop)
                rxr_q <= ~rxr_q;
            rxn_q <= rxn_q + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end
    always @(posedge ref_clk_i) begin
        if (tx_push)
            txf_q[txw_q] <= {tx_wake_up_bit_i, tx_data_i};
        if (rx_push)
            rxf_q[rxw_q] <= rx_word;
    end
endmodule
`default_nettype wire

/* File: tb/usc_core_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module usc_chk (
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic [1:0] clock_select_i,
    input wire logic       clock_out_divide_select_i,
    input wire logic       tx_valid_i,
    input wire logic       tx_ready_o,
    input wire logic       rx_valid_o,
    input wire logic       rx_ready_i,
    input wire logic [7:0] rx_data_o,
    input wire logic       txd_o,
    input wire logic       serial_clk_o,
    input wire logic       tx_fifo_empty_o,
    input wire logic       rx_fifo_full_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rst; $rose(resetn_i) |-> txd_o && !serial_clk_o && tx_fifo_empty_o; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_bit; $changed(txd_o) |=> $stable(txd_o) [*8]; endproperty
    a_bit: assert property (p_bit) else $error("line bit too short");
    property p_byp; (clock_select_i == 2'h1 && !clock_out_divide_select_i) [*3]
        |-> $changed(serial_clk_o); endproperty
    a_byp: assert property (p_byp) else $error("bypass clock not toggling");
    property p_push; tx_valid_i && tx_ready_o && tx_fifo_empty_o |=> !tx_fifo_empty_o; endproperty
    a_push: assert property (p_push) else $error("push lost");
    property p_rxh; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o); endproperty
    a_rxh: assert property (p_rxh) else $error("rx word not held");
    property p_rxf; rx_fifo_full_o |-> rx_valid_o; endproperty
    a_rxf: assert property (p_rxf) else $error("full without data");
    property p_txf; !tx_ready_o |-> !tx_fifo_empty_o; endproperty
    a_txf: assert property (p_txf) else $error("refusing while empty");
    property p_pop; rx_fifo_full_o && rx_ready_i |=> !rx_fifo_full_o; endproperty
    a_pop: assert property (p_pop) else $error("pop did not free");
endmodule
bind usc_core usc_chk chk (.*);
`default_nettype wire

/* File: tb/usc_far.sv */
`timescale 1ns/1ns
`default_nettype none
module usc_far #(parameter int BIT = 128) (
    input  wire logic txd_i,
    output var  logic rxd_o
);
    // same rate and format as the core
    initial rxd_o = 1'b1;
    task automatic send(input logic [8:0] d, input int n, input logic pe, input logic pv,
                        input logic s2);
        rxd_o = 1'b0;
        #BIT;
        for (int i = 0; i < n; i++) begin
            rxd_o = d[i];
            #BIT;
        end
        if (pe) begin
            rxd_o = pv;
            #BIT;
        end
        rxd_o = 1'b1;
        #(s2 ? 2 * BIT : BIT);
    endtask
    // mid-bit sampling keeps the widest margin
    task automatic recv(output logic [8:0] d, output logic pb, output logic sb, output time ts,
                        input int n, input logic pe, input logic s2);
        @(negedge txd_i);
        ts = $time;
        d = 9'h000;
        #(BIT / 2);
        for (int i = 0; i < n; i++) begin
            #BIT;
            d[i] = txd_i;
        end
        #BIT;
        pb = txd_i;
        if (pe) #BIT;
        sb = txd_i;
        if (s2) begin
            #BIT;
            sb = sb & txd_i;
        end
    endtask
    task automatic pulse(input int t);
        rxd_o = 1'b0;
        #t;
        rxd_o = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: tb/usc_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module usc_core_tb;
    logic clk = 1'b0, rstn = 1'b0, ext = 1'b0, cods = 1'b1, two = 1'b0, pen = 1'b0;
    logic podd = 1'b0, msb = 1'b0, wake_up_bit = 1'b0, rxen = 1'b1, txv = 1'b0, rxr = 1'b0;
    logic [1:0] cs = 2'h0, len = 2'h1, lm = 2'h0;
    logic [2:0] psel = 3'h0, ec = 3'h0;
    logic [7:0] div = 8'h00, txd8 = 8'h00, rxd8;
    logic txr, rxx, rxv, txo, sclk, tfe, rff, line;
    logic [6:0] cfg [6] = '{7'h00, 7'h31, 7'h38, 7'h41, 7'h54, 7'h5F};
    logic [13:0] ck [6] = '{14'h1000, 14'h1800, 14'h0803, 14'h0100, 14'h3000, 14'h2001};
    logic [8:0] ckx [6] = '{9'h080, 9'h008, 9'h010, 9'h020, 9'h010, 9'h004};
    int errors = 0, comparisons = 0;
    always #2 clk = ~clk;
    // external source rises once every eight cycles
    always @(negedge clk) begin
        ec <= ec + 3'h1;
        ext <= ec[2];
    end
    usc_core uut (.ref_clk_i(clk), .resetn_i(rstn), .ext_clk_i(ext), .clock_select_i(cs),
        .clock_out_divide_select_i(cods), .prescale_sel_i(psel), .baud_divisor_i(div),
        .data_len_i(len), .two_stop_i(two), .parity_en_i(pen), .parity_odd_i(podd),
        .msb_first_i(msb), .line_mode_field_i(lm), .tx_wake_up_bit_i(wake_up_bit), .rx_enable_i(rxen),
        .tx_data_i(txd8), .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd8),
        .rx_extra_o(rxx), .rx_valid_o(rxv), .rx_ready_i(rxr), .rxd_i(line), .txd_o(txo),
        .serial_clk_o(sclk), .tx_fifo_empty_o(tfe), .rx_fifo_full_o(rff));
    usc_far #(.BIT(128)) far (.txd_i(txo), .rxd_o(line));
    task automatic check(input string n, input logic [8:0] e, input logic [8:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic push(input logic [8:0] d);
        @(negedge clk);
        while (txr !== 1'b1) @(negedge clk);
        txd8 = d[7:0];
        wake_up_bit = d[8];
        txv = 1'b1;
        @(negedge clk);
        txv = 1'b0;
    endtask
    task automatic pop(input logic [8:0] e, input logic [8:0] m);
        @(negedge clk);
        for (int k = 0; k < 3000 && rxv !== 1'b1; k++) @(negedge clk);
        check("rx valid", 9'h001, rxv);
        check("rx word", e & m, {rxx, rxd8} & m);
        rxr = 1'b1;
        @(negedge clk);
        rxr = 1'b0;
    endtask
    task automatic t_formats;
        logic [8:0] g, m, d;
        logic pb, sb, pe, pv;
        time ts;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            {len, pen, podd, lm, two} = cfg[i];
            m = 9'h1FF >> (2 - len);
            d = {i[0], 8'hA5 ^ (8'h3C * i[7:0])} & m;
            pe = pen & ~lm[1];
            pv = ^d ^ podd;
            fork
                push(d);
                far.recv(g, pb, sb, ts, 7 + len, pe, two);
            join
            check("tx data", d, g);
            check("tx parity", pe ? pv : 1'b1, pb);
            check("tx stop", 9'h001, sb);
            far.send(d, 7 + len, pe, pv, two);
            pop(d, m);
        end
        $display("formats done");
    endtask
    task automatic t_b2b;
        logic [8:0] g, r [3];
        logic pb, sb;
        time t [3];
        r = '{9'h072, 9'h0F2, 9'h00A};
        @(negedge clk);
        {len, pen, lm, two, msb} = 7'h21;
        fork
            begin
                for (int i = 0; i < 3; i++) push(9'h04E + 9'(i));
                repeat (8) @(negedge clk);
                check("tx ready", 9'h000, txr);
            end
            for (int i = 0; i < 3; i++) begin
                far.recv(g, pb, sb, t[i], 8, 1'b0, 1'b0);
                check("tx msb first", r[i], g);
            end
        join
        check("tx empty", 9'h001, tfe);
        // ten bits of 16 ticks plus the idle tick that fetches the next word
        check("frame gap", 9'h001, 9'(t[2] - t[1] == 1288));
        far.send(9'h072, 8, 1'b0, 1'b0, 1'b0);
        pop(9'h04E, 9'h0FF);
        msb = 1'b0;
        $display("back to back done");
    endtask
    task automatic t_rxfull;
        for (int i = 0; i < 3; i++) far.send(9'h0C3 ^ 9'(i), 8, 1'b0, 1'b0, 1'b0);
        @(negedge clk);
        check("rx full", 9'h001, rff);
        pop(9'h0C3, 9'h0FF);
        pop(9'h0C2, 9'h0FF);
        check("rx dropped", 9'h000, rxv);
        far.pulse(40);
        repeat (200) @(negedge clk);
        check("rx glitch", 9'h000, rxv);
        rxen = 1'b0;
        far.send(9'h05A, 8, 1'b0, 1'b0, 1'b0);
        @(negedge clk);
        check("rx disabled", 9'h000, rxv);
        rxen = 1'b1;
        far.send(9'h0A6, 8, 1'b0, 1'b0, 1'b0);
        pop(9'h0A6, 9'h0FF);
        $display("receive done");
    endtask
    task automatic t_clk;
        int c;
        logic s;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            {cs, cods, psel, div} = ck[i];
            repeat (80) @(negedge clk);
            c = 0;
            repeat (128) begin
                s = sclk;
                @(negedge clk);
                c += int'(s !== sclk);
            end
            check("serial clock", ckx[i], 9'(c));
        end
        $display("clock done");
    endtask
    task automatic results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        t_formats;
        t_b2b;
        t_rxfull;
        t_clk;
        results;
    end
    initial begin
        #200000;
        errors++;
        results;
    end
endmodule
`default_nettype wire
